// ---- rtl/ecp_debug_port.sv ----
// Emulation debug serial port: debug entry, serial command/data exchange,
// acknowledge pulses and status pin sharing.
// Assumes a processor core that halts on request and reports when halted.
`timescale 1ns/1ps

// Operation
// - Serial input bits are ignored unless debug mode has been entered.
// - Serial input is sampled on each falling edge of the debug clock.
// - Serial words in are sent and assembled most significant bit first.
// - Outside debug mode the input pin drives chip status bit 0.
// - Outside debug mode the clock pin drives status bit 1; else clock input.
// - Input pin goes high-impedance before turning from status output to input.
// - Clock pin goes high-impedance before turning from input to status output.
// - Serial output changes on rising debug clock edges, most significant bit first.
// - The register shifted out is chosen by the latest received command.
// - Entering debug mode pulses the serial output low as acknowledge.
// - After a read command, a low pulse marks the data ready.
// - After a write command, a low pulse marks readiness for the data.
// - After the written word is stored, another low pulse follows.
// - Debug request finishes the instruction, saves pipeline, enters debug mode.
// - In debug mode, request then release after acknowledge resynchronises the port.
// - Debug request wakes the processor from stop or wait.
// - Request held while reset is released enters debug mode instead of running.
module ecp_debug_port (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic debug_in_or_status0_in,
    output logic debug_in_or_status0_out,
    output logic debug_in_or_status0_oe_out,
    input wire logic debug_clk_or_status1_in,
    output logic debug_clk_or_status1_out,
    output logic debug_clk_or_status1_oe_out,
    output logic debug_serial_out_out,
    input wire logic debug_request_n_in,
    input wire logic [1:0] chip_status_in,
    input wire logic core_halted_in,
    output logic core_halt_req_out,
    output logic core_debug_out,
    output logic core_wake_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ecp_pkg::ecp_state_t state_ff;
    ecp_pkg::ecp_state_t nxt_state;
    ecp_pkg::ecp_state_t ret_ff;
    ecp_pkg::ecp_state_t nxt_ret;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic [ecp_pkg::DATA_BITS-1:0] sh_ff;
    logic [ecp_pkg::DATA_BITS-1:0] nxt_sh;
    logic [ecp_pkg::DATA_BITS-1:0] tx_sh_ff;
    logic [ecp_pkg::DATA_BITS-1:0] nxt_tx_sh;
    logic [ecp_pkg::SEL_W-1:0] sel_ff;
    logic [ecp_pkg::SEL_W-1:0] nxt_sel;
    logic go_ff;
    logic nxt_go;
    logic dso_ff;
    logic nxt_dso;
    logic pin_oe_ff;
    logic nxt_pin_oe;
    logic s0_ff;
    logic s1_ff;
    logic halt_req_ff;
    logic debug_ff;
    logic wake_ff;
    logic link_rst_ff;
    logic [2:0] prev_ff;
    logic [ecp_pkg::DATA_BITS-1:0] regs [ecp_pkg::NUM_REGS];

    // ------------------------------------------------------------
    // Link side and crossing
    // ------------------------------------------------------------
    logic rx_bit_l;
    logic rx_tgl_l;
    logic tx_tgl_l;
    logic [2:0] sync_w;

    ecp_link_edge u_link (
        .link_clk_in(debug_clk_or_status1_in),
        .link_rst_in(link_rst_ff),
        .serial_in(debug_in_or_status0_in),
        .rx_bit_out(rx_bit_l),
        .rx_tgl_out(rx_tgl_l),
        .tx_tgl_out(tx_tgl_l)
    );

    ecp_sync #(.WIDTH(3)) u_sync (
        .ref_clk_in(ref_clk_in),
        .clk_en_in(clk_en_in),
        .async_in({debug_request_n_in, tx_tgl_l, rx_tgl_l}),
        .sync_out(sync_w)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire rx_evt = sync_w[0] ^ prev_ff[0];
    wire tx_evt = sync_w[1] ^ prev_ff[1];
    wire dr_s = sync_w[2];
    wire dr_fall = prev_ff[2] & ~sync_w[2];
    wire [ecp_pkg::DATA_BITS-1:0] new_bits = {sh_ff[ecp_pkg::DATA_BITS-2:0], rx_bit_l};
    wire [ecp_pkg::CMD_BITS-1:0] cmd_word = new_bits[ecp_pkg::CMD_BITS-1:0];
    wire cmd_done = (state_ff == ecp_pkg::ST_CMD) && rx_evt && (cnt_ff == ecp_pkg::CMD_LAST);
    wire data_done = (state_ff == ecp_pkg::ST_DATA_IN) && rx_evt && (cnt_ff == ecp_pkg::DATA_LAST);
    wire resync = ecp_pkg::ecp_can_resync(state_ff) && dr_fall;
    wire [ecp_pkg::DATA_BITS-1:0] rd_word = regs[sel_ff];
    wire shift_full = (cnt_ff == 5'(ecp_pkg::DATA_BITS));
    wire shift_edge = (state_ff == ecp_pkg::ST_SHIFT_OUT) && tx_evt && !shift_full;
    wire shift_end = (state_ff == ecp_pkg::ST_SHIFT_OUT) && rx_evt && shift_full;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_ret = ret_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_sel = sel_ff;
        nxt_go = go_ff;
        if (resync) begin
            nxt_state = ecp_pkg::ST_ACK;
            nxt_ret = ecp_pkg::ST_WAIT_REL;
            nxt_cnt = ecp_pkg::CNT_ZERO;
        end else begin
            unique case (state_ff)
                ecp_pkg::ST_BOOT: begin
                    nxt_state = dr_s ? ecp_pkg::ST_RUN : ecp_pkg::ST_HALT;
                end
                ecp_pkg::ST_RUN: begin
                    if (!dr_s) begin
                        nxt_state = ecp_pkg::ST_HALT;
                    end
                end
                ecp_pkg::ST_HALT: begin
                    if (core_halted_in) begin
                        nxt_state = ecp_pkg::ST_HIZ_IN;
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                    end
                end
                ecp_pkg::ST_HIZ_IN: begin
                    nxt_cnt = cnt_ff + ecp_pkg::CNT_ONE;
                    if (cnt_ff == ecp_pkg::HIZ_LAST) begin
                        nxt_state = ecp_pkg::ST_ACK;
                        nxt_ret = ecp_pkg::ST_WAIT_REL;
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                    end
                end
                ecp_pkg::ST_ACK: begin
                    nxt_cnt = cnt_ff + ecp_pkg::CNT_ONE;
                    if (cnt_ff == ecp_pkg::ACK_LAST) begin
                        nxt_state = ret_ff;
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                    end
                end
                ecp_pkg::ST_WAIT_REL: begin
                    if (dr_s) begin
                        nxt_state = ecp_pkg::ST_CMD;
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                    end
                end
                ecp_pkg::ST_CMD: begin
                    if (rx_evt) begin
                        nxt_sh = new_bits;
                        nxt_cnt = cnt_ff + ecp_pkg::CNT_ONE;
                    end
                    if (cmd_done) begin
                        nxt_sel = cmd_word[ecp_pkg::SEL_W-1:0];
                        nxt_go = cmd_word[ecp_pkg::CMD_GO_POS];
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                        if (cmd_word[ecp_pkg::CMD_RD_POS]) begin
                            nxt_state = ecp_pkg::ST_RD_PREP;
                        end else begin
                            nxt_state = ecp_pkg::ST_ACK;
                            nxt_ret = ecp_pkg::ST_DATA_IN;
                        end
                    end
                end
                ecp_pkg::ST_RD_PREP: begin
                    nxt_tx_sh = rd_word;
                    nxt_state = ecp_pkg::ST_ACK;
                    nxt_ret = ecp_pkg::ST_SHIFT_OUT;
                    nxt_cnt = ecp_pkg::CNT_ZERO;
                end
                ecp_pkg::ST_SHIFT_OUT: begin
                    if (shift_edge) begin
                        nxt_tx_sh = {tx_sh_ff[ecp_pkg::DATA_BITS-2:0], 1'h0};
                        nxt_cnt = cnt_ff + ecp_pkg::CNT_ONE;
                    end else if (shift_end) begin
                        nxt_state = ecp_pkg::ST_CMD;
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                    end
                end
                ecp_pkg::ST_DATA_IN: begin
                    if (rx_evt) begin
                        nxt_sh = new_bits;
                        nxt_cnt = cnt_ff + ecp_pkg::CNT_ONE;
                    end
                    if (data_done) begin
                        nxt_state = ecp_pkg::ST_STORE;
                    end
                end
                ecp_pkg::ST_STORE: begin
                    nxt_state = ecp_pkg::ST_ACK;
                    nxt_ret = go_ff ? ecp_pkg::ST_LEAVE : ecp_pkg::ST_CMD;
                    nxt_cnt = ecp_pkg::CNT_ZERO;
                end
                ecp_pkg::ST_LEAVE: begin
                    nxt_cnt = cnt_ff + ecp_pkg::CNT_ONE;
                    if (cnt_ff == ecp_pkg::HIZ_LAST) begin
                        nxt_state = ecp_pkg::ST_RUN;
                        nxt_cnt = ecp_pkg::CNT_ZERO;
                    end
                end
                default: begin
                    nxt_state = ecp_pkg::ST_BOOT;
                end
            endcase
        end
    end

    // Acknowledge low wins; after it the line idles high until a bit is shifted
    assign nxt_dso = (nxt_state == ecp_pkg::ST_ACK) ? ecp_pkg::ACK_LEVEL :
                     shift_edge ? tx_sh_ff[ecp_pkg::DATA_BITS-1] :
                     (state_ff == ecp_pkg::ST_ACK) ? ecp_pkg::DSO_IDLE : dso_ff;
    // Pins drive status only outside debug; the hi-Z states sit on both turns
    assign nxt_pin_oe = !ecp_pkg::ecp_in_debug(nxt_state);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        link_rst_ff <= sys_rst_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_ff <= ecp_pkg::ST_BOOT;
            ret_ff <= ecp_pkg::ST_WAIT_REL;
            cnt_ff <= ecp_pkg::CNT_ZERO;
            sh_ff <= '0;
            tx_sh_ff <= '0;
            sel_ff <= '0;
            go_ff <= 1'h0;
            dso_ff <= ecp_pkg::DSO_IDLE;
        end else if (clk_en_in) begin
            state_ff <= nxt_state;
            ret_ff <= nxt_ret;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            tx_sh_ff <= nxt_tx_sh;
            sel_ff <= nxt_sel;
            go_ff <= nxt_go;
            dso_ff <= nxt_dso;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pin_oe_ff <= 1'h1;
            s0_ff <= ecp_pkg::PIN_RST;
            s1_ff <= ecp_pkg::PIN_RST;
            halt_req_ff <= 1'h1;
            debug_ff <= 1'h0;
            wake_ff <= 1'h0;
            prev_ff <= sync_w;
        end else if (clk_en_in) begin
            pin_oe_ff <= nxt_pin_oe;
            s0_ff <= chip_status_in[0];
            s1_ff <= chip_status_in[1];
            halt_req_ff <= (nxt_state != ecp_pkg::ST_RUN);
            debug_ff <= ecp_pkg::ecp_in_debug(nxt_state);
            wake_ff <= !dr_s;
            prev_ff <= sync_w;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (clk_en_in && state_ff == ecp_pkg::ST_STORE) begin
            regs[sel_ff] <= sh_ff;
        end
    end

    assign debug_in_or_status0_out = s0_ff;
    assign debug_in_or_status0_oe_out = pin_oe_ff;
    assign debug_clk_or_status1_out = s1_ff;
    assign debug_clk_or_status1_oe_out = pin_oe_ff;
    assign debug_serial_out_out = dso_ff;
    assign core_halt_req_out = halt_req_ff;
    assign core_debug_out = debug_ff;
    assign core_wake_out = wake_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in || !clk_en_in);

    wire ack_st = (state_ff == ecp_pkg::ST_ACK);

    a_ignore_idle_bits:
        assert property ((state_ff == ecp_pkg::ST_RUN) |=> (sh_ff == $past(sh_ff)))
        else $error("serial input taken outside debug mode");
    a_msb_first_in:
        assert property ((state_ff == ecp_pkg::ST_CMD && rx_evt && !resync) |=>
            (sh_ff == {$past(sh_ff[22:0]), $past(rx_bit_l)}))
        else $error("input word not assembled msb first");
    a_status0_drive:
        assert property ((state_ff == ecp_pkg::ST_RUN && $past(clk_en_in)) |->
            (debug_in_or_status0_oe_out && debug_in_or_status0_out == $past(chip_status_in[0])))
        else $error("status bit 0 not driven outside debug");
    a_status1_drive:
        assert property ((state_ff == ecp_pkg::ST_CMD) |->
            (!debug_clk_or_status1_oe_out && !debug_in_or_status0_oe_out))
        else $error("clock pin driven in debug mode");
    a_hiz_before_in:
        assert property ($fell(pin_oe_ff) |-> (!pin_oe_ff)[*2] ##1 (!pin_oe_ff && !dso_ff))
        else $error("input pin not hi-z before acknowledge");
    a_hiz_before_out:
        assert property ($rose(pin_oe_ff) && $past(debug_ff) |->
            ($past(state_ff, 2) == ecp_pkg::ST_LEAVE && $past(pin_oe_ff, 2) == 1'h0))
        else $error("clock pin not hi-z before status drive");
    a_ack_low_width:
        assert property ($rose(ack_st) |-> (!dso_ff && ack_st)[*8] ##1 (dso_ff || ack_st))
        else $error("acknowledge pulse width wrong");
    a_dso_rising:
        assert property (shift_edge && !resync |=> (dso_ff == $past(tx_sh_ff[23])))
        else $error("serial output not msb at rising edge");
    a_read_ready:
        assert property ((state_ff == ecp_pkg::ST_RD_PREP && !resync) |=>
            (!dso_ff && tx_sh_ff == $past(rd_word) && ret_ff == ecp_pkg::ST_SHIFT_OUT))
        else $error("read data or acknowledge missing");
    a_write_ready:
        assert property ((cmd_done && !resync && !cmd_word[ecp_pkg::CMD_RD_POS]) |=>
            (!dso_ff && ret_ff == ecp_pkg::ST_DATA_IN))
        else $error("write acknowledge missing");
    a_store_ack:
        assert property ((state_ff == ecp_pkg::ST_STORE && !resync) |=>
            (!dso_ff && regs[$past(sel_ff)] == $past(sh_ff)))
        else $error("store acknowledge or data missing");
    a_resync_ack:
        assert property (resync |=> (ack_st && ret_ff == ecp_pkg::ST_WAIT_REL && cnt_ff == 5'h00))
        else $error("resync did not restart acknowledge");
    a_halt_enter:
        assert property ((state_ff == ecp_pkg::ST_RUN && !dr_s) |=> (halt_req_ff ##[1:300] 1'h1))
        else $error("debug request did not halt core");
    a_wake_core:
        assert property (!dr_s |=> core_wake_out)
        else $error("debug request did not wake core");
    a_boot_debug:
        assert property ((state_ff == ecp_pkg::ST_BOOT && !dr_s) |=>
            (state_ff == ecp_pkg::ST_HALT && halt_req_ff))
        else $error("boot with request did not halt");

    c_read_done: cover property (state_ff == ecp_pkg::ST_SHIFT_OUT ##1 state_ff == ecp_pkg::ST_CMD);
    c_write_store: cover property (state_ff == ecp_pkg::ST_STORE);
    c_resync: cover property (resync);
    c_boot_debug: cover property (state_ff == ecp_pkg::ST_BOOT && !dr_s);

endmodule // ecp_debug_port

// ---- rtl/ecp_link_edge.sv ----
// Link-clock side of the debug port: captures each serial bit and flags
// every clock edge with a toggle for the processor domain to pick up.
// Assumes the link clock is at most one eighth of the processor clock.
`timescale 1ns/1ps
module ecp_link_edge (
    input wire logic link_clk_in,
    input wire logic link_rst_in,
    input wire logic serial_in,
    output logic rx_bit_out,
    output logic rx_tgl_out,
    output logic tx_tgl_out
);

    logic rx_bit_ff;
    logic rx_tgl_ff;
    logic tx_tgl_ff;

    // Bit held until the next falling edge, so it is stable when read
    always_ff @(negedge link_clk_in or posedge link_rst_in) begin
        if (link_rst_in) begin
            rx_bit_ff <= 1'h0;
            rx_tgl_ff <= 1'h0;
        end else begin
            rx_bit_ff <= serial_in;
            rx_tgl_ff <= ~rx_tgl_ff;
        end
    end

    always_ff @(posedge link_clk_in or posedge link_rst_in) begin
        if (link_rst_in) begin
            tx_tgl_ff <= 1'h0;
        end else begin
            tx_tgl_ff <= ~tx_tgl_ff;
        end
    end

    assign rx_bit_out = rx_bit_ff;
    assign rx_tgl_out = rx_tgl_ff;
    assign tx_tgl_out = tx_tgl_ff;

endmodule // ecp_link_edge

// ---- rtl/ecp_pkg.sv ----
// Constants, state type and decode helpers for the emulation debug serial port.
// Assumes a 125 MHz processor clock; the link clock arrives from the controller.
package ecp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int ACK_NS = 64;
    localparam int HIZ_NS = 16;
    localparam logic [4:0] ACK_LAST = 5'((ACK_NS + CLK_NS - 1) / CLK_NS - 1);
    localparam logic [4:0] HIZ_LAST = 5'((HIZ_NS + CLK_NS - 1) / CLK_NS - 1);

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 24;
    localparam int SEL_W = 4;
    localparam int NUM_REGS = 16;
    localparam int CMD_RD_POS = 7;
    localparam int CMD_GO_POS = 6;
    localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
    localparam logic [4:0] DATA_LAST = 5'(DATA_BITS - 1);
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;

    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    localparam logic ACK_LEVEL = 1'h0;
    localparam logic DSO_IDLE = 1'h1;
    localparam logic PIN_RST = 1'h0;

    typedef enum logic [3:0] {
        ST_BOOT, ST_RUN, ST_HALT, ST_HIZ_IN, ST_ACK, ST_WAIT_REL,
        ST_CMD, ST_RD_PREP, ST_SHIFT_OUT, ST_DATA_IN, ST_STORE, ST_LEAVE
    } ecp_state_t;

    function automatic logic ecp_in_debug(input ecp_state_t st);
        return !(st inside {ST_BOOT, ST_RUN, ST_HALT});
    endfunction

    function automatic logic ecp_can_resync(input ecp_state_t st);
        return st inside {ST_ACK, ST_CMD, ST_RD_PREP, ST_SHIFT_OUT, ST_DATA_IN, ST_STORE};
    endfunction

endpackage

// ---- rtl/ecp_sync.sv ----
// Two-flop level synchroniser into the processor clock domain.
// Assumes inputs change no faster than the destination clock can see.
`timescale 1ns/1ps
module ecp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge ref_clk_in) begin
        if (clk_en_in) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // ecp_sync

// ---- verification/ecp_ctl_model.sv ----
// External debug command controller model for the serial debug port.
// Assumes the data pin has a pull-down; the model drives the clock pin itself.
`timescale 1ns/1ps
module ecp_ctl_model (
    input wire logic dev_oe_in,
    input wire logic status0_in,
    input wire logic status1_in,
    input wire logic serial_out_in,
    output logic data_pin_out,
    output logic clk_pin_out,
    output logic req_n_out
);
    logic lclk = 1'h0;
    logic ldata = 1'h0;
    logic drv = 1'h0;
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    assign data_pin_out = dev_oe_in ? status0_in : (drv ? ldata : 1'h0);
    assign clk_pin_out = dev_oe_in ? status1_in : lclk;
    initial req_n_out = 1'h1;
    task automatic set_req(input logic lvl);
        req_n_out = lvl;
    endtask
    // Link clock stands low between frames; last bit ends at its falling edge
    task automatic xfer(input int n, input logic [23:0] wr, output logic [23:0] rd);
        rd = 24'h000000;
        drv = 1'h1;
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            lclk = 1'h1;
            ldata = wr[i];
            #62.5;
            rd = {rd[22:0], serial_out_in};
            lclk = 1'h0;
            #(i > 0 ? 62.5 : 10.0);
        end
        drv = 1'h0;
    endtask
endmodule // ecp_ctl_model

// ---- verification/testbench.sv ----
// Self-checking bench for the emulation debug serial port.
// Assumes the core halts half a cycle after it is asked to.
`timescale 1ns/1ps
module testbench;
    logic ref_clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic clk_en_in = 1'h1;
    logic [1:0] chip_status_in = 2'h0;
    logic core_halted_in = 1'h0;
    logic data_pin, clk_pin, req_n, s0_out, s0_oe, s1_out, s1_oe, debug_serial_out, halt_req, dbg, wake;
    logic [23:0] rd;
    int mismatches = 0;
    int checked = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    always @(negedge ref_clk_in) core_halted_in <= halt_req;
    ecp_debug_port u_ecp_debug_port (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .debug_in_or_status0_in(data_pin), .debug_in_or_status0_out(s0_out), .debug_in_or_status0_oe_out(s0_oe),
        .debug_clk_or_status1_in(clk_pin), .debug_clk_or_status1_out(s1_out), .debug_clk_or_status1_oe_out(s1_oe),
        .debug_serial_out_out(debug_serial_out), .debug_request_n_in(req_n), .chip_status_in(chip_status_in),
        .core_halted_in(core_halted_in), .core_halt_req_out(halt_req), .core_debug_out(dbg), .core_wake_out(wake));
    ecp_ctl_model u_ecp_ctl_model (.dev_oe_in(s0_oe), .status0_in(s0_out), .status1_in(s1_out),
        .serial_out_in(debug_serial_out), .data_pin_out(data_pin), .clk_pin_out(clk_pin), .req_n_out(req_n));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? debug_serial_out : (w == 1 ? s0_oe : halt_req);
    endfunction
    task automatic wait_on(input int w, input logic lvl);
        int n = 0;
        while (pick(w) !== lvl) begin
            @(negedge ref_clk_in);
            n++;
            if (n > 2000) begin
                mismatches++;
                $display("unexpected wait %0d: expected %b, seen timeout", w, lvl);
                report_and_stop();
            end
        end
    endtask
    task automatic ack(input string name);
        int n = 0;
        wait_on(0, 1'h0);
        chk({name, "_oe"}, 24'(s0_oe), 24'h0);
        while (debug_serial_out === 1'h0 && n < 20) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk(name, 24'(n), 24'h8);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_status(input logic [1:0] s);
        @(negedge ref_clk_in);
        chip_status_in = s;
        repeat (2) @(negedge ref_clk_in);
        chk("status", 24'({s1_out, s0_out}), 24'(s));
        chk("status_oe", 24'({s1_oe, s0_oe}), 24'h3);
        $display("status test done");
    endtask
    task automatic t_freeze;
        @(negedge ref_clk_in);
        clk_en_in = 1'h0;
        chip_status_in = 2'h1;
        repeat (3) @(negedge ref_clk_in);
        chk("frozen", 24'({s1_out, s0_out}), 24'h2);
        clk_en_in = 1'h1;
        repeat (2) @(negedge ref_clk_in);
        chk("thawed", 24'({s1_out, s0_out}), 24'h1);
        $display("freeze test done");
    endtask
    task automatic t_entry;
        u_ecp_ctl_model.set_req(1'h0);
        wait_on(2, 1'h1);
        chk("wake", 24'(wake), 24'h1);
        ack("entry_ack");
        chk("debug", 24'(dbg), 24'h1);
        chk("clk_oe", 24'(s1_oe), 24'h0);
        u_ecp_ctl_model.set_req(1'h1);
        repeat (6) @(negedge ref_clk_in);
        u_ecp_ctl_model.xfer(4, 24'h00000f, rd);
        u_ecp_ctl_model.set_req(1'h0);
        ack("resync_ack");
        u_ecp_ctl_model.set_req(1'h1);
        repeat (6) @(negedge ref_clk_in);
        $display("entry test done");
    endtask
    task automatic t_write(input logic [7:0] cmd, input logic [23:0] w);
        u_ecp_ctl_model.xfer(8, 24'(cmd), rd);
        ack("cmd_ack");
        u_ecp_ctl_model.xfer(24, w, rd);
        ack("store_ack");
        $display("write test done");
    endtask
    task automatic t_read(input logic [3:0] sel, input logic [23:0] w);
        u_ecp_ctl_model.xfer(8, {16'h0000, 4'h8, sel}, rd);
        ack("read_ack");
        u_ecp_ctl_model.xfer(24, 24'h000000, rd);
        chk("read_word", rd, w);
        $display("read test done");
    endtask
    task automatic t_leave;
        t_write(8'h45, 24'h123457);
        wait_on(1, 1'h1);
        chk("left_debug", 24'(dbg), 24'h0);
        repeat (2) @(negedge ref_clk_in);
        chk("status_back", 24'({s1_out, s0_out}), 24'h2);
        $display("leave test done");
    endtask
    task automatic t_boot;
        u_ecp_ctl_model.set_req(1'h0);
        sys_rst_in = 1'h1;
        repeat (16) @(negedge ref_clk_in);
        sys_rst_in = 1'h0;
        ack("boot_ack");
        chk("boot_debug", 24'(dbg), 24'h1);
        $display("boot test done");
    endtask
    initial begin
        repeat (16) @(negedge ref_clk_in);
        sys_rst_in = 1'h0;
        repeat (4) @(negedge ref_clk_in);
        t_status(2'h1);
        t_status(2'h2);
        t_freeze();
        t_status(2'h2);
        t_entry();
        t_write(8'h03, 24'ha5c3f1);
        t_write(8'h05, 24'h5a3c0f);
        t_read(4'h3, 24'ha5c3f1);
        t_read(4'h5, 24'h5a3c0f);
        t_leave();
        t_boot();
        report_and_stop();
    end
endmodule // testbench
